//--- power_domain_control.sv
// Power domain control: resets, supply detectors, battery charging, clock choice and domain switches.
//
// Contract
// - Backup reset comes only from backup power-on reset or software backup reset; the code also asserts it while rst_n_in is low.
// - Backup logic stays in reset while backup power-on reset is asserted.
// - Writing one to the backup soft reset bit resets all backup logic.
// - RTC source is internal 32k oscillator, low-speed crystal, or high-speed crystal/32.
// - With main supply off only the low-speed crystal stays a usable RTC source.
// - On battery supply the backup pins serve only clock and crystal roles.
// - Charge resistor select chooses the 5 kOhm or 1.5 kOhm resistor.
// - Battery charging is active only while charge enable is set.
// - Battery-only state forces charging off regardless of charge enable.
// - Core regulator is enabled after reset, then follows the requested mode state.
// - Supply reset from detectors resets the whole chip except backup domain.
// - Base brownout always acts; extra brownout trips at the option-byte threshold.
// - Voltage detector works only when enabled and reports against the 3-bit threshold.
// - Detector output drives external event line 16; event controller decides interrupts.
// - Threshold 111 compares the external pin against 0.8V instead of supply.
// - Core domain power-up runs a reset sequence over its logic.
// - Secondary SRAM switches off alone and is on after system reset.
// - Cipher domain is off after reset; software powers it on before use.
// - Flash power-off bit removes flash power; software sets it before lowering voltage.
// - Flash deep-sleep-off bit switches flash off on deep-sleep entry.
// - Switchable core domain is off in deepest sleep; retention bit keeps CPU registers.
`default_nettype none
module power_domain_control
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic backup_power_on_reset_n_in,
   input wire logic backup_domain_soft_reset_in,
   input wire logic battery_only_state_in,
   input wire logic base_brownout_detector_in,
   input wire logic brownout_detect_in,
   input wire logic supply_reset_detector_in,
   input wire logic [1:0] rtc_source_select_in,
   input wire logic internal_32k_oscillator_tick_in,
   input wire logic low_speed_crystal_tick_in,
   input wire logic high_speed_crystal_tick_in,
   input wire logic charge_resistor_select_in,
   input wire logic charge_enable_in,
   input wire logic [1:0] ldo_mode_request_in,
   input wire logic lvd_enable_in,
   input wire logic [2:0] lvd_threshold_in,
   input wire logic supply_below_threshold_in,
   input wire logic pin_below_ref_in,
   input wire logic core_power_good_in,
   input wire logic sram_off_in,
   input wire logic cipher_on_in,
   input wire logic flash_power_off_in,
   input wire logic flash_deepsleep_off_in,
   input wire logic cpu_register_retention_in,
   input wire logic deepsleep_in,
   input wire logic deepest_sleep_in,
   output logic backup_reset_n_out,
   output logic chip_reset_n_out,
   output logic core_reset_n_out,
   output logic rtc_tick_out,
   output logic [1:0] rtc_source_active_out,
   output logic backup_pin_gpio_allowed_out,
   output logic charge_on_out,
   output logic charge_resistor_1k5_out,
   output logic ldo_enable_out,
   output logic [1:0] ldo_state_out,
   output logic voltage_detect_flag_out,
   output logic event_line16_out,
   output logic comparator_use_pin_out,
   output logic [2:0] comparator_level_out,
   output logic sram_power_on_out,
   output logic cipher_power_on_out,
   output logic flash_power_on_out,
   output logic core_power_on_out,
   output logic cpu_register_retention_out
);
   typedef enum logic [1:0] {core_idle, core_rst_seq, core_running} core_state_t;

   logic backup_power_on_reset_s;
   logic soft_s;
   logic batt_s;
   logic base_brownout_detector_s;
   logic bor_s;
   logic por_s;
   logic lvd_supply_s;
   logic lvd_pin_s;
   logic good_s;
   logic ds_s;
   logic dds_s;
   logic div_tick;

   power_domain_pkg::domain_ctl_t ctl;
   power_domain_pkg::domain_pwr_t pwr_r;
   power_domain_pkg::domain_pwr_t pwr_nxt;
   power_domain_pkg::lvd_ctl_t lvd_ctl;

   // Bring the reset, battery, detector, core-good and sleep levels into the clock domain first.
   level_sync u_sync_backup_power_on_reset (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(backup_power_on_reset_n_in), .q_out(backup_power_on_reset_s));
   level_sync u_sync_soft (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(backup_domain_soft_reset_in), .q_out(soft_s));
   level_sync u_sync_batt (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(battery_only_state_in), .q_out(batt_s));
   level_sync u_sync_base_brownout_detector (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(base_brownout_detector_in), .q_out(base_brownout_detector_s));
   level_sync u_sync_bor (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(brownout_detect_in), .q_out(bor_s));
   level_sync u_sync_por (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(supply_reset_detector_in), .q_out(por_s));
   level_sync u_sync_lvs (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(supply_below_threshold_in), .q_out(lvd_supply_s));
   level_sync u_sync_lvp (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(pin_below_ref_in), .q_out(lvd_pin_s));
   level_sync u_sync_good (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(core_power_good_in), .q_out(good_s));
   level_sync u_sync_ds (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(deepsleep_in), .q_out(ds_s));
   level_sync u_sync_dds (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .d_in(deepest_sleep_in), .q_out(dds_s));

   rtc_div32 u_div (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .tick_in(high_speed_crystal_tick_in), .tick_out(div_tick));

   assign ctl.sram_off = sram_off_in;
   assign ctl.cipher_on = cipher_on_in;
   assign ctl.flash_power_off = flash_power_off_in;
   assign ctl.flash_deepsleep_off = flash_deepsleep_off_in;
   assign ctl.cpu_register_retention = cpu_register_retention_in;
   assign lvd_ctl.enable = lvd_enable_in;
   assign lvd_ctl.threshold = lvd_threshold_in;

   // Reset generation.
   logic bkrst_n_r;
   logic bkrst_n_nxt;
   logic chiprst_n_r;
   logic chiprst_n_nxt;
   logic corerst_n_r;
   logic corerst_n_nxt;
   core_state_t core_st_r;
   core_state_t core_st_nxt;
   logic [7:0] seq_cnt_r;
   logic [7:0] seq_cnt_nxt;

   always_comb
   begin
      bkrst_n_nxt = backup_power_on_reset_s && !soft_s;
      chiprst_n_nxt = !(por_s || base_brownout_detector_s || bor_s);
      core_st_nxt = core_st_r;
      seq_cnt_nxt = seq_cnt_r;
      corerst_n_nxt = 1'b0;
      case (core_st_r)
         core_idle:
         begin
            if (good_s && chiprst_n_r)
            begin
               core_st_nxt = core_rst_seq;
               seq_cnt_nxt = 8'h00;
            end
         end
         core_rst_seq:
         begin
            seq_cnt_nxt = 8'(seq_cnt_r + 8'h01);
            if (seq_cnt_r == 8'(power_domain_pkg::core_reset_cycles - 1))
            begin
               core_st_nxt = core_running;
               corerst_n_nxt = 1'b1;
            end
         end
         core_running:
         begin
            corerst_n_nxt = 1'b1;
         end
         default:
         begin
            core_st_nxt = core_idle;
         end
      endcase
      if (!good_s || !chiprst_n_r)
      begin
         core_st_nxt = core_idle;
         corerst_n_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         bkrst_n_r <= 1'b0;
         chiprst_n_r <= 1'b0;
         corerst_n_r <= 1'b0;
         core_st_r <= core_idle;
         seq_cnt_r <= 8'h00;
      end
      else
      begin
         bkrst_n_r <= bkrst_n_nxt;
         chiprst_n_r <= chiprst_n_nxt;
         corerst_n_r <= corerst_n_nxt;
         core_st_r <= core_st_nxt;
         seq_cnt_r <= seq_cnt_nxt;
      end
   end

   // Clock choice, pin roles and battery charging.
   logic rtc_tick_r;
   logic rtc_tick_nxt;
   logic [1:0] rtc_src_r;
   logic [1:0] rtc_src_nxt;
   logic gpio_ok_r;
   logic gpio_ok_nxt;
   logic charge_r;
   logic charge_nxt;
   logic res_r;
   logic res_nxt;

   always_comb
   begin
      rtc_src_nxt = rtc_source_select_in;
      if (batt_s && rtc_source_select_in != power_domain_pkg::rtc_src_low_speed_crystal)
      begin
         rtc_src_nxt = power_domain_pkg::rtc_src_none;
      end
      case (rtc_src_nxt)
         power_domain_pkg::rtc_src_irc: rtc_tick_nxt = internal_32k_oscillator_tick_in;
         power_domain_pkg::rtc_src_low_speed_crystal: rtc_tick_nxt = low_speed_crystal_tick_in;
         power_domain_pkg::rtc_src_high_speed_crystal: rtc_tick_nxt = div_tick;
         default: rtc_tick_nxt = 1'b0;
      endcase
      gpio_ok_nxt = !batt_s;
      charge_nxt = charge_enable_in && !batt_s;
      res_nxt = (charge_resistor_select_in == power_domain_pkg::charge_res_1k5);
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rtc_tick_r <= 1'b0;
         rtc_src_r <= power_domain_pkg::rtc_src_none;
         gpio_ok_r <= 1'b0;
         charge_r <= 1'b0;
         res_r <= 1'b0;
      end
      else
      begin
         rtc_tick_r <= rtc_tick_nxt;
         rtc_src_r <= rtc_src_nxt;
         gpio_ok_r <= gpio_ok_nxt;
         charge_r <= charge_nxt;
         res_r <= res_nxt;
      end
   end

   // Regulator and low-voltage detector.
   logic ldo_en_r;
   logic ldo_en_nxt;
   logic [1:0] ldo_st_r;
   logic [1:0] ldo_st_nxt;
   logic voltage_detect_flag_r;
   logic voltage_detect_flag_nxt;
   logic usepin_r;
   logic usepin_nxt;
   logic [2:0] level_r;
   logic [2:0] level_nxt;

   always_comb
   begin
      ldo_st_nxt = ldo_mode_request_in;
      ldo_en_nxt = (ldo_mode_request_in != power_domain_pkg::ldo_off);
      usepin_nxt = lvd_ctl.enable && (lvd_ctl.threshold == power_domain_pkg::thr_ext_pin);
      level_nxt = lvd_ctl.threshold;
      voltage_detect_flag_nxt = 1'b0;
      if (lvd_ctl.enable)
      begin
         voltage_detect_flag_nxt = usepin_r ? lvd_pin_s : lvd_supply_s;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         ldo_en_r <= 1'b1;
         ldo_st_r <= power_domain_pkg::ldo_full;
         voltage_detect_flag_r <= 1'b0;
         usepin_r <= 1'b0;
         level_r <= 3'h0;
      end
      else
      begin
         ldo_en_r <= ldo_en_nxt;
         ldo_st_r <= ldo_st_nxt;
         voltage_detect_flag_r <= voltage_detect_flag_nxt;
         usepin_r <= usepin_nxt;
         level_r <= level_nxt;
      end
   end

   // Domain power switches.
   always_comb
   begin
      pwr_nxt.sram_on = !ctl.sram_off && !dds_s;
      pwr_nxt.cipher_on = ctl.cipher_on && !dds_s;
      pwr_nxt.flash_on = !ctl.flash_power_off && !(ds_s && ctl.flash_deepsleep_off);
      pwr_nxt.core_on = !dds_s;
      pwr_nxt.retain = ctl.cpu_register_retention;
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         pwr_r.sram_on <= power_domain_pkg::rst_val_sram_on;
         pwr_r.cipher_on <= power_domain_pkg::rst_val_cipher_on;
         pwr_r.flash_on <= power_domain_pkg::rst_val_flash_on;
         pwr_r.core_on <= 1'b1;
         pwr_r.retain <= 1'b0;
      end
      else
      begin
         pwr_r <= pwr_nxt;
      end
   end

   assign backup_reset_n_out = bkrst_n_r;
   assign chip_reset_n_out = chiprst_n_r;
   assign core_reset_n_out = corerst_n_r;
   assign rtc_tick_out = rtc_tick_r;
   assign rtc_source_active_out = rtc_src_r;
   assign backup_pin_gpio_allowed_out = gpio_ok_r;
   assign charge_on_out = charge_r;
   assign charge_resistor_1k5_out = res_r;
   assign ldo_enable_out = ldo_en_r;
   assign ldo_state_out = ldo_st_r;
   assign voltage_detect_flag_out = voltage_detect_flag_r;
   assign event_line16_out = voltage_detect_flag_r;
   assign comparator_use_pin_out = usepin_r;
   assign comparator_level_out = level_r;
   assign sram_power_on_out = pwr_r.sram_on;
   assign cipher_power_on_out = pwr_r.cipher_on;
   assign flash_power_on_out = pwr_r.flash_on;
   assign core_power_on_out = pwr_r.core_on;
   assign cpu_register_retention_out = pwr_r.retain;
endmodule
`default_nettype wire

//--- power_domain_pkg.sv
// Constants and carrier types shared by the power domain control files.
`default_nettype none
package power_domain_pkg;
   localparam int sync_stages = 2;
   localparam int clk_period_ns = 5;
   localparam int core_reset_time_ns = 100;
   localparam int core_reset_cycles = (core_reset_time_ns + clk_period_ns - 1) / clk_period_ns;
   localparam int high_speed_crystal_div = 32;
   localparam logic [2:0] thr_ext_pin = 3'h7;
   localparam logic [1:0] rtc_src_none = 2'h0;
   localparam logic [1:0] rtc_src_irc = 2'h1;
   localparam logic [1:0] rtc_src_low_speed_crystal = 2'h2;
   localparam logic [1:0] rtc_src_high_speed_crystal = 2'h3;
   localparam logic charge_res_5k = 1'b0;
   localparam logic charge_res_1k5 = 1'b1;
   localparam logic [1:0] ldo_full = 2'h0;
   localparam logic [1:0] ldo_low = 2'h1;
   localparam logic [1:0] ldo_off = 2'h2;
   localparam logic rst_val_sram_on = 1'b1;
   localparam logic rst_val_cipher_on = 1'b0;
   localparam logic rst_val_flash_on = 1'b1;

   typedef struct packed
   {
      logic sram_off;
      logic cipher_on;
      logic flash_power_off;
      logic flash_deepsleep_off;
      logic cpu_register_retention;
   } domain_ctl_t;

   typedef struct packed
   {
      logic sram_on;
      logic cipher_on;
      logic flash_on;
      logic core_on;
      logic retain;
   } domain_pwr_t;

   typedef struct packed
   {
      logic enable;
      logic [2:0] threshold;
   } lvd_ctl_t;
endpackage
`default_nettype wire

//--- level_sync.sv
// Two-stage synchroniser for a level from another domain.
`default_nettype none
module level_sync
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic d_in,
   output logic q_out
);
   logic meta_r;
   logic meta_nxt;
   logic q_r;
   logic q_nxt;

   always_comb
   begin
      meta_nxt = d_in;
      q_nxt = meta_r;
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_r <= 1'b0;
         q_r <= 1'b0;
      end
      else
      begin
         meta_r <= meta_nxt;
         q_r <= q_nxt;
      end
   end

   assign q_out = q_r;
endmodule
`default_nettype wire

//--- rtc_div32.sv
// Divides the high-speed crystal clock enable stream by 32 for the real-time clock.
`default_nettype none
module rtc_div32
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic tick_in,
   output logic tick_out
);
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic tick_r;
   logic tick_nxt;

   always_comb
   begin
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (tick_in)
      begin
         cnt_nxt = 5'(cnt_r + 5'h01);
         tick_nxt = (cnt_r == 5'(power_domain_pkg::high_speed_crystal_div - 1));
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cnt_r <= 5'h00;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_out = tick_r;
endmodule
`default_nettype wire

//--- power_domain_control_sva.sv
// Concurrent checks on the power domain control ports.
`default_nettype none
module power_domain_control_sva
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic backup_power_on_reset_n_in,
   input wire logic backup_domain_soft_reset_in,
   input wire logic battery_only_state_in,
   input wire logic base_brownout_detector_in,
   input wire logic brownout_detect_in,
   input wire logic supply_reset_detector_in,
   input wire logic [1:0] rtc_source_select_in,
   input wire logic low_speed_crystal_tick_in,
   input wire logic charge_resistor_select_in,
   input wire logic charge_enable_in,
   input wire logic lvd_enable_in,
   input wire logic supply_below_threshold_in,
   input wire logic core_power_good_in,
   input wire logic sram_off_in,
   input wire logic cipher_on_in,
   input wire logic flash_power_off_in,
   input wire logic flash_deepsleep_off_in,
   input wire logic deepsleep_in,
   input wire logic deepest_sleep_in,
   input wire logic backup_reset_n_out,
   input wire logic chip_reset_n_out,
   input wire logic core_reset_n_out,
   input wire logic rtc_tick_out,
   input wire logic [1:0] rtc_source_active_out,
   input wire logic charge_on_out,
   input wire logic charge_resistor_1k5_out,
   input wire logic voltage_detect_flag_out,
   input wire logic event_line16_out,
   input wire logic comparator_use_pin_out,
   input wire logic sram_power_on_out,
   input wire logic cipher_power_on_out,
   input wire logic flash_power_on_out
);
   logic [2:0] up_cnt_r;
   logic warm;
   default clocking cb @(posedge mclk_in);
   endclocking
   default disable iff (!rst_n_in);
   // Counts edges since reset release so that three-cycle look-backs see only live inputs.
   always_ff @(posedge mclk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         up_cnt_r <= 3'h0;
      else if (up_cnt_r != 3'h7)
         up_cnt_r <= up_cnt_r + 3'h1;
   end
   assign warm = (up_cnt_r >= 3'h4);
   sequence s_core_rise;
      $rose(core_power_good_in) && chip_reset_n_out && warm;
   endsequence
   sequence s_core_hold;
      (!core_reset_n_out)[*8];
   endsequence
   a_backup_reset_src: assert property (warm |-> backup_reset_n_out ==
      ($past(backup_power_on_reset_n_in, 3) && !$past(backup_domain_soft_reset_in, 3)))
      else $error("backup reset does not follow its two sources");
   a_chip_reset_src: assert property (warm |-> chip_reset_n_out == !($past(base_brownout_detector_in, 3) ||
      $past(brownout_detect_in, 3) || $past(supply_reset_detector_in, 3)))
      else $error("chip reset does not follow the detectors");
   a_charge_gate: assert property (warm |-> charge_on_out ==
      ($past(charge_enable_in) && !$past(battery_only_state_in, 3)))
      else $error("charging state wrong");
   a_charge_res: assert property (warm |-> charge_resistor_1k5_out == $past(charge_resistor_select_in))
      else $error("charge resistor choice wrong");
   a_rtc_source_gate: assert property (warm |-> rtc_source_active_out ==
      (($past(battery_only_state_in, 3) && $past(rtc_source_select_in) != power_domain_pkg::rtc_src_low_speed_crystal) ?
      power_domain_pkg::rtc_src_none : $past(rtc_source_select_in)))
      else $error("clock source choice wrong");
   a_rtc_low_speed_crystal_tick: assert property (low_speed_crystal_tick_in ##1
      (rtc_source_active_out == power_domain_pkg::rtc_src_low_speed_crystal) |-> rtc_tick_out)
      else $error("crystal tick lost");
   a_sram_switch: assert property (warm |-> sram_power_on_out ==
      (!$past(sram_off_in) && !$past(deepest_sleep_in, 3)))
      else $error("secondary memory power wrong");
   a_cipher_switch: assert property (warm |-> cipher_power_on_out ==
      ($past(cipher_on_in) && !$past(deepest_sleep_in, 3)))
      else $error("cipher power wrong");
   a_flash_switch: assert property (warm |-> flash_power_on_out == (!$past(flash_power_off_in) &&
      !($past(deepsleep_in, 3) && $past(flash_deepsleep_off_in))))
      else $error("flash power wrong");
   a_lvd_off: assert property ((warm && !lvd_enable_in)[*5] |-> !voltage_detect_flag_out)
      else $error("flag set while detector disabled");
   a_event_follow: assert property (warm && $past(lvd_enable_in) && !$past(comparator_use_pin_out) |->
      event_line16_out == $past(supply_below_threshold_in, 3))
      else $error("event line does not follow the supply comparator");
   a_core_seq: assert property (s_core_rise |=> s_core_hold ##[10:20] core_reset_n_out)
      else $error("core reset sequence wrong");
endmodule
bind power_domain_control power_domain_control_sva power_domain_control_sva_i (.*);
`default_nettype wire

//--- tb_power_domain_control.sv
// Self-checking testbench for the power domain control block.
`default_nettype none
module tb_power_domain_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_in, rst_n_in, backup_power_on_reset_n_in, backup_domain_soft_reset_in, battery_only_state_in;
   logic base_brownout_detector_in, brownout_detect_in, supply_reset_detector_in, charge_resistor_select_in;
   logic internal_32k_oscillator_tick_in, low_speed_crystal_tick_in, high_speed_crystal_tick_in, charge_enable_in;
   logic lvd_enable_in, supply_below_threshold_in, pin_below_ref_in, core_power_good_in, sram_off_in, cipher_on_in;
   logic flash_power_off_in, flash_deepsleep_off_in, cpu_register_retention_in, deepsleep_in, deepest_sleep_in;
   logic [1:0] rtc_source_select_in, ldo_mode_request_in, rtc_source_active_out, ldo_state_out;
   logic [2:0] lvd_threshold_in, comparator_level_out;
   logic backup_reset_n_out, chip_reset_n_out, core_reset_n_out, rtc_tick_out, backup_pin_gpio_allowed_out;
   logic charge_on_out, charge_resistor_1k5_out, ldo_enable_out, voltage_detect_flag_out, event_line16_out;
   logic comparator_use_pin_out, sram_power_on_out, cipher_power_on_out, flash_power_on_out, core_power_on_out;
   logic cpu_register_retention_out;
   logic [9:0] dom_tab [6] = '{10'h00b, 10'h307, 10'h18d, 10'h16d, 10'h12f, 10'h112};
   int mismatches, cmp_count, ticks;
   power_domain_control power_domain_control_i (.*);
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk_in);
      @(negedge mclk_in);
   endtask
   task automatic pulse(input int n, input int which);
      repeat (n)
      begin
         @(posedge mclk_in);
         internal_32k_oscillator_tick_in <= (which == 0);
         low_speed_crystal_tick_in <= (which == 1);
         high_speed_crystal_tick_in <= (which == 2);
         @(posedge mclk_in);
         {internal_32k_oscillator_tick_in, low_speed_crystal_tick_in, high_speed_crystal_tick_in} <= 3'h0;
      end
      settle(4);
   endtask
   task automatic complete_run();
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      mclk_in = 1'b0;
      forever #2.5 mclk_in = ~mclk_in;
   end
   always @(posedge mclk_in)
      if (rtc_tick_out === 1'b1)
         ticks++;
   initial
   begin
      repeat (3000) @(posedge mclk_in);
      mismatches++;
      complete_run();
   end
   initial
   begin
      {rst_n_in, backup_domain_soft_reset_in, battery_only_state_in, base_brownout_detector_in} = 4'h0;
      {brownout_detect_in, supply_reset_detector_in, charge_resistor_select_in, charge_enable_in} = 4'h0;
      {internal_32k_oscillator_tick_in, low_speed_crystal_tick_in, high_speed_crystal_tick_in} = 3'h0;
      {lvd_enable_in, supply_below_threshold_in, pin_below_ref_in, sram_off_in, cipher_on_in} = 5'h00;
      {flash_power_off_in, flash_deepsleep_off_in, cpu_register_retention_in, deepsleep_in} = 4'h0;
      {deepest_sleep_in, rtc_source_select_in, ldo_mode_request_in, lvd_threshold_in} = 8'h00;
      {backup_power_on_reset_n_in, core_power_good_in} = 2'h3;
      settle(3);
      check("ldo_en", 4'(ldo_enable_out), 4'h1);
      check("domains", {sram_power_on_out, cipher_power_on_out, flash_power_on_out, core_power_on_out}, 4'hb);
      check("resets", {chip_reset_n_out, backup_reset_n_out, voltage_detect_flag_out, cpu_register_retention_out}, 4'h0);
      @(posedge mclk_in);
      rst_n_in <= 1'b1;
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         @(posedge mclk_in);
         {backup_domain_soft_reset_in, backup_power_on_reset_n_in} <= 2'(i);
         settle(4);
         check("backup_rst", {chip_reset_n_out, backup_reset_n_out}, {1'b1, i == 1});
      end
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk_in);
         backup_domain_soft_reset_in <= 1'b0;
         {base_brownout_detector_in, brownout_detect_in, supply_reset_detector_in} <= 3'(1 << i);
         settle(4);
         check("chip_rst", {chip_reset_n_out, backup_reset_n_out}, 4'h1);
      end
      @(posedge mclk_in);
      {base_brownout_detector_in, brownout_detect_in, supply_reset_detector_in} <= 3'h0;
      $display("test resets done");
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk_in);
         {charge_resistor_select_in, battery_only_state_in, charge_enable_in} <= 3'(i);
         settle(4);
         check("charge", {charge_resistor_1k5_out, charge_on_out}, {i[2], i[1:0] == 2'h1});
      end
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk_in);
         {battery_only_state_in, rtc_source_select_in} <= 3'(i);
         settle(4);
         check("rtc_src", {backup_pin_gpio_allowed_out, rtc_source_active_out},
            {!i[2], (i[2] && i[1:0] != 2'h2) ? 2'h0 : i[1:0]});
      end
      @(posedge mclk_in);
      {battery_only_state_in, rtc_source_select_in} <= {1'b0, power_domain_pkg::rtc_src_high_speed_crystal};
      settle(4);
      ticks = 0;
      pulse(64, 2);
      check("hx_ticks", 4'(ticks), 4'(64 / power_domain_pkg::high_speed_crystal_div));
      @(posedge mclk_in);
      rtc_source_select_in <= power_domain_pkg::rtc_src_irc;
      settle(4);
      ticks = 0;
      pulse(3, 0);
      check("irc_ticks", 4'(ticks), 4'h3);
      @(posedge mclk_in);
      battery_only_state_in <= 1'b1;
      settle(4);
      ticks = 0;
      pulse(3, 0);
      check("bat_irc", 4'(ticks), 4'h0);
      @(posedge mclk_in);
      rtc_source_select_in <= power_domain_pkg::rtc_src_low_speed_crystal;
      settle(4);
      ticks = 0;
      pulse(3, 1);
      check("bat_lx", 4'(ticks), 4'h3);
      $display("test clock done");
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk_in);
         ldo_mode_request_in <= 2'(i);
         settle(4);
         check("ldo", {ldo_enable_out, ldo_state_out}, {i != 2, 2'(i)});
      end
      @(posedge mclk_in);
      {supply_below_threshold_in, lvd_threshold_in} <= 4'hb;
      settle(5);
      check("lvd_off", {voltage_detect_flag_out, event_line16_out, comparator_use_pin_out}, 4'h0);
      @(posedge mclk_in);
      lvd_enable_in <= 1'b1;
      settle(5);
      check("lvd_on", {voltage_detect_flag_out, event_line16_out, comparator_level_out}, 8'h1b);
      @(posedge mclk_in);
      lvd_threshold_in <= power_domain_pkg::thr_ext_pin;
      settle(5);
      check("lvd_pin", {voltage_detect_flag_out, event_line16_out, comparator_use_pin_out}, 4'h1);
      @(posedge mclk_in);
      pin_below_ref_in <= 1'b1;
      settle(5);
      check("lvd_pin", {voltage_detect_flag_out, event_line16_out, comparator_use_pin_out}, 4'h7);
      $display("test detector done");
      for (int i = 0; i < 6; i++)
      begin
         @(posedge mclk_in);
         {sram_off_in, cipher_on_in, flash_power_off_in} <= dom_tab[i][9:7];
         {flash_deepsleep_off_in, deepsleep_in, deepest_sleep_in, cpu_register_retention_in} <= {dom_tab[i][6:4], 1'b1};
         settle(4);
         check("dom", {sram_power_on_out, cipher_power_on_out, flash_power_on_out, core_power_on_out},
            dom_tab[i][3:0]);
      end
      check("retain", 4'(cpu_register_retention_out), 4'h1);
      @(posedge mclk_in);
      {deepest_sleep_in, core_power_good_in} <= 2'h0;
      settle(5);
      check("core_rst", 4'(core_reset_n_out), 4'h0);
      @(posedge mclk_in);
      core_power_good_in <= 1'b1;
      settle(10);
      check("core_rst", 4'(core_reset_n_out), 4'h0);
      settle(20);
      check("core_rst", 4'(core_reset_n_out), 4'h1);
      $display("test domains done");
      complete_run();
   end
endmodule
`default_nettype wire
